// ### verilog/alert_pkg.sv
/*
 * Shared constants for the alert masking and extended-resolution block:
 * register offsets, bit positions, reset values and the freeze states.
 * Assumes an 8-bit register address space served by a serial slave engine.
 */
package alert_pkg;

	// register offsets in the 8-bit register space
	localparam logic [7:0] ADDR_MASK_FIRST = 8'h74;
	localparam logic [7:0] ADDR_MASK_SECOND = 8'h75;
	localparam logic [7:0] ADDR_LOW_BITS = 8'h76;
	// high-byte results, one per voltage channel; base must be 4-aligned
	localparam logic [7:0] ADDR_HIGH_BASE = 8'h20;

	// reset values
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] LOW_BITS_RESET = 8'h00;
	localparam logic [7:0] HIGH_RESET = 8'h00;

	// first mask register fields
	localparam int M1_VOLT25_BIT = 0;
	localparam int M1_CORE_BIT = 1;
	localparam int M1_SUPPLY_BIT = 2;
	localparam int M1_VOLT5_BIT = 3;
	localparam int M1_SUMMARY_BIT = 7;

	// second mask register fields
	localparam int M2_V12_BIT = 0;
	localparam int M2_SUMMARY_BIT = 1;
	localparam int M2_FAN_ONE_BIT = 2;
	localparam int M2_FAN_FOUR_BIT = 5;

	// conversion results
	localparam int VOLT_CH = 4;
	localparam int LSB_W = 2;
	localparam int RESULT_W = 10;

	// freeze state of the extended-resolution readback
	typedef enum logic [1:0] {
		FRZ_LIVE = 2'b01,
		FRZ_HELD = 2'b10
	} freeze_type;

endpackage

// ### verilog/alert_if.sv
/*
 * Carrier between the register side and the alert gate: mask values,
 * event levels, pin configuration and the registered open-drain drive.
 * Assumes both ends run on the same system clock.
 */
interface alert_if;
	logic [7:0] mask_first; // first mask register
	logic [7:0] mask_second; // second mask register
	logic [6:0] stat_one; // per-channel events of the first status group
	logic [6:0] stat_two; // per-channel events of the second status group
	logic summary_fourth; // summary of the fourth status group
	logic summary_out_of_range; // summary of the second status group
	logic v12_mode; // shared pin measures 12 V
	logic alert_en; // shared pin acts as alert output
	logic pin_out; // open-drain level when driven
	logic pin_oe_n; // low while the pin is pulled

	modport regs (
		output mask_first, mask_second, stat_one, stat_two, summary_fourth,
		output v12_mode, alert_en,
		input summary_out_of_range, pin_out, pin_oe_n
	);
	modport gate (
		input mask_first, mask_second, stat_one, stat_two, summary_fourth,
		input v12_mode, alert_en,
		output summary_out_of_range, pin_out, pin_oe_n
	);
endinterface

// ### verilog/alert_gate.sv
/*
 * Alert gate: combines event levels with the two mask registers and
 * drives the open-drain alert pin from flip-flops.
 * Assumes event levels come from logic on the same clock.
 */
module alert_gate (
	input wire logic clk_sys, // system clock
	input wire logic nrst, // async reset, active low
	alert_if.gate a // masks, events and pin drive
);
	import alert_pkg::*;

	logic v12_mask_eff;
	logic [6:0] mask_two_eff;
	logic hit_one;
	logic hit_two;
	logic hit_sum_one;
	logic hit_sum_two;
	logic alert_req;

	// summary bit of the first group sets on any second-group event
	assign a.summary_out_of_range = (|a.stat_two) | a.summary_fourth;
	// 12 V mask only counts while the pin measures 12 V
	assign v12_mask_eff = a.mask_second[M2_V12_BIT] & a.v12_mode; // R7
	assign mask_two_eff = {a.mask_second[7:M2_FAN_ONE_BIT], v12_mask_eff}; // R9 R11
	// per-channel paths
	assign hit_one = |(a.stat_one & ~a.mask_first[6:0]); // R1 R2 R3 R4 R5
	assign hit_two = |(a.stat_two & ~mask_two_eff); // R9 R10 R11
	// summary paths ignore the per-channel masks, so both must be set
	assign hit_sum_one = a.summary_out_of_range & ~a.mask_first[M1_SUMMARY_BIT]; // R6
	assign hit_sum_two = a.summary_fourth & ~a.mask_second[M2_SUMMARY_BIT]; // R8
	assign alert_req = hit_one | hit_two | hit_sum_one | hit_sum_two;

	// pin released whenever the shared pin is not the alert output
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			a.pin_oe_n <= 1'b1;
			a.pin_out <= 1'b1;
		end else begin
			a.pin_oe_n <= ~(a.alert_en & alert_req); // R16
			a.pin_out <= ~(a.alert_en & alert_req);
		end
	end

	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	logic quiet_two;
	assign quiet_two = (a.stat_two == 7'h00) && !a.summary_fourth;

	property quiet_p(logic c);
		c |=> a.pin_oe_n;
	endproperty
	property loud_p(logic c);
		c |=> !a.pin_oe_n;
	endproperty

	volt25_mask_a: assert property (quiet_p(a.alert_en && quiet_two // R1
		&& a.stat_one == 7'h01 && a.mask_first[M1_VOLT25_BIT]))
		else $error("masked 2.5 V event drove alert");
	volt25_open_a: assert property (loud_p(a.alert_en && quiet_two // R1
		&& a.stat_one == 7'h01 && !a.mask_first[M1_VOLT25_BIT]))
		else $error("unmasked 2.5 V event did not drive alert");
	rail_mask_a: assert property (quiet_p(a.alert_en && quiet_two && // R2
		((a.stat_one == 7'h02 && a.mask_first[M1_CORE_BIT]) ||
		(a.stat_one == 7'h04 && a.mask_first[M1_SUPPLY_BIT]) ||
		(a.stat_one == 7'h08 && a.mask_first[M1_VOLT5_BIT]))))
		else $error("masked rail event drove alert");
	remote_one_a: assert property (quiet_p(a.alert_en && quiet_two // R3
		&& a.stat_one == 7'h10 && a.mask_first[4]))
		else $error("masked remote one event drove alert");
	local_temp_a: assert property (quiet_p(a.alert_en && quiet_two // R4
		&& a.stat_one == 7'h20 && a.mask_first[5]))
		else $error("masked local event drove alert");
	remote_two_a: assert property (quiet_p(a.alert_en && quiet_two // R5
		&& a.stat_one == 7'h40 && a.mask_first[6]))
		else $error("masked remote two event drove alert");
	summary_one_a: assert property (loud_p(a.alert_en && a.stat_one == 7'h00 // R6
		&& a.stat_two == 7'h02 && !a.summary_fourth && a.mask_second[M2_FAN_ONE_BIT]
		&& !a.mask_first[M1_SUMMARY_BIT]))
		else $error("summary path lost behind per-channel mask");
	v12_mode_a: assert property (loud_p(a.alert_en && a.stat_one == 7'h00 // R7
		&& a.stat_two == 7'h01 && !a.summary_fourth && a.mask_second[M2_V12_BIT]
		&& !a.v12_mode && a.mask_first[M1_SUMMARY_BIT]))
		else $error("12 V mask acted while pin not in 12 V mode");
	summary_two_a: assert property (loud_p(a.alert_en && a.stat_one == 7'h00 // R8
		&& a.stat_two == 7'h00 && a.summary_fourth && a.mask_second[M2_SUMMARY_BIT]
		&& !a.mask_first[M1_SUMMARY_BIT]))
		else $error("second summary blocked by wrong mask");
	fan_two_a: assert property (quiet_p(a.alert_en && a.stat_one == 7'h00 // R9
		&& a.stat_two == 7'h04 && !a.summary_fourth && a.mask_second[3]
		&& a.mask_first[M1_SUMMARY_BIT]))
		else $error("masked fan two fault drove alert");
	diode_one_a: assert property (quiet_p(a.alert_en && a.stat_one == 7'h00 // R11
		&& a.stat_two == 7'h20 && !a.summary_fourth && a.mask_second[6]
		&& a.mask_first[M1_SUMMARY_BIT]))
		else $error("masked diode fault drove alert");
	pin_release_a: assert property (!a.alert_en |=> a.pin_oe_n && a.pin_out) // R16
		else $error("alert pin pulled while not configured");
endmodule

// ### verilog/alert_mask_and_ext_resolution.sv
/*
 * Alert masking and extended-resolution readback.
 * Holds the two alert mask registers, the low-bits register of four
 * voltage readings with their high bytes, and the freeze on readback.
 * Assumes a serial slave engine that turns bus transfers into one-cycle
 * read and write strobes with an 8-bit address, and event levels and
 * conversion results from logic on the same clock.
 */

// Contract
// R1: mask bit 0 of the first register keeps 2.5 V or timer events off the alert pin.
// R2: mask bits 1 to 3 of the first register keep core, supply and 5 V events off the pin.
// R3: mask bit 4 of the first register keeps remote one temperature events off the pin.
// R4: mask bit 5 of the first register keeps local temperature events off the pin.
// R5: mask bit 6 of the first register keeps remote two temperature events off the pin.
// R6: mask bit 7 of the first register blocks the summary bit, apart from the second register.
// R7: mask bit 0 of the second register masks 12 V events only while the pin measures 12 V.
// R8: mask bit 1 of the second register blocks the second summary, apart from any third mask.
// R9: mask bits 2 to 4 of the second register keep fan one to three faults off the pin.
// R10: mask bit 5 of the second register masks fan four or the timer limit, by pin use.
// R11: mask bits 6 and 7 of the second register keep diode one and two faults off the pin.
// R12: both mask registers come out of reset cleared.
// R13: the low-bits register is read-only and holds the two low bits of four readings.
// R14: reading the low-bits register freezes it and the high bytes until those are read.
// R15: the low-bits register reads zero after reset until a result arrives.
// R16: the alert pin is driven only while the alert enable is set.
// R17: masking touches only the pin; the status view still shows every event.
module alert_mask_and_ext_resolution #(
	parameter int NUM_CH = 4 // voltage channels sharing the low-bits register
) (
	input wire logic clk_sys, // system clock, 100 MHz
	input wire logic nrst, // async reset, active low
	input wire logic [7:0] reg_addr, // register address
	input wire logic reg_wr, // write strobe, one cycle
	input wire logic reg_rd, // read strobe, one cycle
	input wire logic [7:0] reg_wdata, // write data
	output logic [7:0] reg_rdata, // read data, valid after a read
	input wire logic [3:0] volt_limit, // 2.5 V/timer, core, supply, 5 V events
	input wire logic [2:0] temp_limit, // remote one, local, remote two events
	input wire logic v12_limit, // 12 V event
	input wire logic [2:0] fan_fault, // fans one to three fault
	input wire logic fan_four_fault, // fan four tach fault
	input wire logic thermal_timer_limit, // thermal timer limit exceeded
	input wire logic diode_one_fault, // remote one diode open or short
	input wire logic diode_two_fault, // remote two diode open or short
	input wire logic summary_fourth, // summary of the fourth status group
	input wire logic alert_enable, // shared pin is the alert output
	input wire logic v12_mode, // shared pin measures 12 V
	input wire logic pin_is_timer, // shared pin is the thermal input
	input wire logic conv_valid, // conversion result strobe
	input wire logic [1:0] conv_ch, // conversion channel
	input wire logic [alert_pkg::RESULT_W-1:0] conv_data, // conversion result
	input wire logic alert_pin_in, // level seen on the alert pin
	output logic alert_pin_out, // alert pin drive level
	output logic alert_pin_oe_n, // alert pin enable, low while pulling
	output logic alert_line_low, // synchronised alert wire is low
	output logic readback_frozen, // results frozen by a low-bits read
	output logic [7:0] status_one, // unmasked first status view
	output logic [7:0] status_two // unmasked second status view
);
	import alert_pkg::*;

	// the low-bits register holds exactly one pair per channel
	if (NUM_CH * LSB_W != 8) begin : bad_ch
		$error("NUM_CH must fill the 8-bit low-bits register");
	end

	alert_if a ();

	alert_gate u_gate (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.a(a)
	);

	// ------------------------------------------------------------
	// alert pin level, brought in from outside the clock domain
	// ------------------------------------------------------------
	logic line_meta_q;
	logic line_sync_q;
	logic line_low_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			line_meta_q <= 1'b1;
			line_sync_q <= 1'b1;
			line_low_q <= 1'b0;
		end else begin
			line_meta_q <= alert_pin_in;
			line_sync_q <= line_meta_q;
			line_low_q <= ~line_sync_q;
		end
	end

	assign alert_line_low = line_low_q;
	assign alert_pin_out = a.pin_out;
	assign alert_pin_oe_n = a.pin_oe_n;

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------
	wire hit_mask_first = reg_addr == ADDR_MASK_FIRST;
	wire hit_mask_second = reg_addr == ADDR_MASK_SECOND;
	wire hit_low = reg_addr == ADDR_LOW_BITS;
	wire hit_high = reg_addr[7:2] == ADDR_HIGH_BASE[7:2];
	wire wr_mask_first = reg_wr & hit_mask_first;
	wire wr_mask_second = reg_wr & hit_mask_second;
	wire rd_low = reg_rd & hit_low;

	// ------------------------------------------------------------
	// alert mask registers
	// ------------------------------------------------------------
	logic [7:0] mask_first_q;
	logic [7:0] mask_second_q;

	// writes to the low-bits offset fall through: that register is read-only
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mask_first_q <= MASK_RESET; // R12
			mask_second_q <= MASK_RESET; // R12
		end else begin
			if (wr_mask_first) begin
				mask_first_q <= reg_wdata;
			end
			if (wr_mask_second) begin
				mask_second_q <= reg_wdata;
			end
		end
	end

	// ------------------------------------------------------------
	// event levels toward the gate
	// ------------------------------------------------------------
	logic fan_four_or_timer;

	// one mask bit, two meanings, picked by the shared pin's use
	assign fan_four_or_timer = pin_is_timer ? thermal_timer_limit : fan_four_fault; // R10

	assign a.mask_first = mask_first_q;
	assign a.mask_second = mask_second_q;
	assign a.stat_one = {temp_limit, volt_limit};
	assign a.stat_two = {diode_two_fault, diode_one_fault, fan_four_or_timer,
		fan_fault, v12_limit};
	assign a.summary_fourth = summary_fourth;
	assign a.v12_mode = v12_mode;
	assign a.alert_en = alert_enable;

	// ------------------------------------------------------------
	// unmasked status view
	// ------------------------------------------------------------
	logic [7:0] status_one_q;
	logic [7:0] status_two_q;

	// masks are not applied here, so software still sees masked events
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			status_one_q <= 8'h00;
			status_two_q <= 8'h00;
		end else begin
			status_one_q <= {a.summary_out_of_range, a.stat_one}; // R17
			status_two_q <= {a.stat_two[6:1], summary_fourth, a.stat_two[0]}; // R17
		end
	end

	assign status_one = status_one_q;
	assign status_two = status_two_q;

	// ------------------------------------------------------------
	// conversion results and the freeze on readback
	// ------------------------------------------------------------
	freeze_type frz_q;
	logic [NUM_CH-1:0] pending_q;
	logic [NUM_CH-1:0] hi_rd;
	logic [7:0] hi_q [NUM_CH];
	logic [LSB_W-1:0] lo_q [NUM_CH];
	logic [7:0] low_bits;
	logic upd_ok;

	// an update in the same cycle as the freezing read is dropped too,
	// so the frozen pair always matches what the host just saw
	assign upd_ok = (frz_q == FRZ_LIVE) && !rd_low; // R14

	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		assign hi_rd[g] = reg_rd && hit_high && (reg_addr[1:0] == 2'(g));
		assign low_bits[LSB_W*g +: LSB_W] = lo_q[g]; // R13

		// result storage, written only while live
		always_ff @(posedge clk_sys or negedge nrst) begin
			if (!nrst) begin
				hi_q[g] <= HIGH_RESET;
				lo_q[g] <= LOW_BITS_RESET[LSB_W*g +: LSB_W]; // R15
			end else if (conv_valid && conv_ch == 2'(g) && upd_ok) begin
				hi_q[g] <= conv_data[RESULT_W-1:LSB_W];
				lo_q[g] <= conv_data[LSB_W-1:0];
			end
		end

		// a fresh low-bits read wins over a high-byte read that cycle
		always_ff @(posedge clk_sys or negedge nrst) begin
			if (!nrst) begin
				pending_q[g] <= 1'b0;
			end else if (rd_low) begin
				pending_q[g] <= 1'b1; // R14
			end else if (hi_rd[g]) begin
				pending_q[g] <= 1'b0; // R14
			end
		end
	end

	// held until every high byte has been read once
	wire all_hi_done = (pending_q & ~hi_rd) == '0;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			frz_q <= FRZ_LIVE;
		end else begin
			unique case (frz_q)
				FRZ_LIVE: begin
					if (rd_low) begin
						frz_q <= FRZ_HELD; // R14
					end
				end
				FRZ_HELD: begin
					if (!rd_low && all_hi_done) begin
						frz_q <= FRZ_LIVE; // R14
					end
				end
			endcase
		end
	end

	assign readback_frozen = frz_q[1];

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	wire [7:0] rd_value = hit_mask_first ? mask_first_q :
		hit_mask_second ? mask_second_q :
		hit_low ? low_bits : // R13
		hit_high ? hi_q[reg_addr[1:0]] : 8'h00;

	// unmapped offsets answer zero; data stands until the next read
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_value;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	logic first_q;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end

	sequence low_read_s;
		rd_low && !hit_mask_first;
	endsequence
	sequence held_quiet_s;
		frz_q == FRZ_HELD && !reg_rd;
	endsequence

	mask_reset_a: assert property (first_q |-> mask_first_q == 8'h00 && // R12
		mask_second_q == 8'h00)
		else $error("mask registers not clear after reset");
	low_reset_a: assert property (first_q |-> low_bits == 8'h00) // R15
		else $error("low-bits register not zero after reset");
	low_read_a: assert property (rd_low |=> reg_rdata == $past(low_bits)) // R13
		else $error("low-bits read returned wrong value");
	freeze_set_a: assert property (low_read_s |=> held_quiet_s[*3] // R14
		|-> $stable(low_bits) && $stable(hi_q[0]))
		else $error("frozen results changed");
	freeze_hold_a: assert property (low_read_s ##1 (!hi_rd[NUM_CH-1])[*3] // R14
		|-> frz_q == FRZ_HELD)
		else $error("freeze released before all high bytes read");
	freeze_release_a: assert property (frz_q == FRZ_HELD && !rd_low && // R14
		hi_rd == pending_q |=> frz_q == FRZ_LIVE)
		else $error("freeze not released after high bytes read");
	fan_four_sel_a: assert property (pin_is_timer && thermal_timer_limit // R10
		&& !fan_four_fault |=> status_two_q[M2_FAN_FOUR_BIT])
		else $error("timer limit not routed to fan four slot");
	status_view_a: assert property (volt_limit[0] && mask_first_q[M1_VOLT25_BIT] // R17
		|=> status_one_q[0])
		else $error("masked event missing from status view");
	mask_write_a: assert property (wr_mask_second ##1 !reg_wr ##1 // R9
		reg_rd && hit_mask_second |=> reg_rdata == $past(reg_wdata, 3))
		else $error("second mask write not read back");
endmodule

// ### testbench/smbus_host_model.sv
/*
 * Host model: register reads and writes as one-cycle strobes, and the
 * pulled-up alert wire resolved from the device drive.
 * Assumes the register port of the alert block on the same clock.
 */
module smbus_host_model (
	input wire logic clk_sys, // system clock
	output logic [7:0] reg_addr, // register address
	output logic reg_wr, // write strobe
	output logic reg_rd, // read strobe
	output logic [7:0] reg_wdata, // write data
	input wire logic alert_pin_out, // device drive level
	input wire logic alert_pin_oe_n, // device pulls while low
	output logic alert_pin_in // resolved wire level
);
	timeunit 1ns;
	timeprecision 1ps;

	// pull-up wins whenever the device lets go
	assign alert_pin_in = alert_pin_oe_n ? 1'b1 : alert_pin_out;

	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end

	// idle bus shows inverted values so stale data never looks valid
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = wr;
		reg_rd = ~wr;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
endmodule

// ### testbench/tb_alert_mask_and_ext_resolution.sv
/*
 * Self-checking bench for alert masking and extended-resolution readback.
 * Assumes the host model and the design package are compiled first.
 */
module tb_alert_mask_and_ext_resolution;
	timeunit 1ns;
	timeprecision 1ps;
	import alert_pkg::*;

	logic clk_sys, nrst, reg_wr, reg_rd, v12_mode, pin_is_timer, alert_enable, conv_valid;
	logic alert_pin_in, alert_pin_out, alert_pin_oe_n, alert_line_low, readback_frozen;
	logic rd_pend = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, status_one, status_two;
	logic [15:0] ev;
	logic [1:0] conv_ch;
	logic [RESULT_W-1:0] conv_data;
	logic [7:0] exp_q[$];
	int n_mismatch = 0;
	int compares = 0;

	alert_mask_and_ext_resolution u_dut (
		.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.volt_limit(ev[3:0]), .temp_limit(ev[6:4]), .v12_limit(ev[7]),
		.summary_fourth(ev[8]),
		.fan_fault(ev[11:9]), .fan_four_fault(ev[12]), .thermal_timer_limit(ev[13]),
		.diode_one_fault(ev[14]), .diode_two_fault(ev[15]), .alert_enable(alert_enable),
		.v12_mode(v12_mode), .pin_is_timer(pin_is_timer), .conv_valid(conv_valid),
		.conv_ch(conv_ch), .conv_data(conv_data), .alert_pin_in(alert_pin_in),
		.alert_pin_out(alert_pin_out), .alert_pin_oe_n(alert_pin_oe_n),
		.alert_line_low(alert_line_low), .readback_frozen(readback_frozen),
		.status_one(status_one), .status_two(status_two)
	);

	smbus_host_model u_host (
		.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .alert_pin_out(alert_pin_out),
		.alert_pin_oe_n(alert_pin_oe_n), .alert_pin_in(alert_pin_in)
	);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// read data shows in the cycle after the strobe; oldest note is matched
	always @(posedge clk_sys) rd_pend <= reg_rd;
	always @(negedge clk_sys) begin
		if (rd_pend === 1'b1) begin
			if (exp_q.size() == 0) begin
				n_mismatch++;
				$display("ERROR %0t read without expectation", $time);
			end else begin
				chk(reg_rdata, exp_q.pop_front(), "read data");
			end
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.access(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.access(1'b0, a, 8'h00);
	endtask

	// extra edge lets the registered pin follow the new masks
	task automatic masks(input logic [7:0] m1, input logic [7:0] m2);
		wr(ADDR_MASK_FIRST, m1);
		wr(ADDR_MASK_SECOND, m2);
		@(negedge clk_sys);
	endtask

	task automatic drive(input logic [15:0] v);
		@(negedge clk_sys);
		ev = v;
		@(negedge clk_sys);
	endtask

	task automatic chk_pin(input logic pull);
		chk({7'h00, alert_pin_oe_n}, {7'h00, ~pull}, "pin enable");
		if (pull) chk({7'h00, alert_pin_out}, 8'h00, "pin level");
	endtask

	task automatic conv(input logic [1:0] c, input logic [9:0] d);
		@(negedge clk_sys);
		conv_valid = 1'b1;
		conv_ch = c;
		conv_data = d;
		@(negedge clk_sys);
		conv_valid = 1'b0;
		conv_ch = ~c;
		conv_data = ~d;
	endtask

	// watchdog sized well beyond the few hundred cycles the run needs
	initial begin
		#100000;
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		logic [9:0] res[4];
		logic [7:0] lo, m;
		int bt;
		nrst = 1'b0;
		ev = 16'h0000;
		alert_enable = 1'b1;
		v12_mode = 1'b1;
		pin_is_timer = 1'b0;
		conv_valid = 1'b0;
		conv_ch = 2'h0;
		conv_data = 10'h000;
		void'($urandom(82056));
		repeat (8) @(negedge clk_sys);
		nrst = 1'b1;
		// reset values; the low-bits read freezes until high bytes are read
		rd(ADDR_MASK_FIRST, MASK_RESET);
		rd(ADDR_MASK_SECOND, MASK_RESET);
		rd(ADDR_LOW_BITS, LOW_BITS_RESET);
		for (int c = 0; c < 4; c++) rd(ADDR_HIGH_BASE + 8'(c), HIGH_RESET);
		rd(8'h10, 8'h00);
		m = 8'($urandom);
		wr(ADDR_MASK_FIRST, m);
		rd(ADDR_MASK_FIRST, m);
		wr(ADDR_MASK_SECOND, ~m);
		rd(ADDR_MASK_SECOND, ~m);
		// each source pulls the pin, its mask (plus the summary mask from ev[7] up) releases it, status stays
		for (int i = 0; i < 16; i++) begin
			bt = (i < 13) ? i - 7 : i - 8;
			pin_is_timer = (i == 13);
			masks(8'h00, 8'h00);
			drive(16'(1) << i);
			chk_pin(1'b1);
			if (i < 7) begin
				masks(8'(1) << i, 8'h00);
				chk(status_one, 8'(1) << i, "status one");
			end else begin
				masks(8'h00, 8'(1) << bt);
				chk_pin(1'b1);
				masks(8'h80, 8'(1) << bt);
				chk(status_two, 8'(1) << bt, "status two");
				chk(status_one, 8'h80, "summary");
			end
			chk_pin(1'b0);
			drive(16'h0000);
		end
		pin_is_timer = 1'b0;
		// 12 V mask does nothing while the pin is not measuring 12 V
		v12_mode = 1'b0;
		masks(8'h80, 8'h01);
		drive(16'h0080);
		chk_pin(1'b1);
		drive(16'h0000);
		v12_mode = 1'b1;
		// timer limit is not a source while the shared pin counts fan four
		masks(8'h00, 8'h00);
		drive(16'h2000);
		chk_pin(1'b0);
		chk(status_two, 8'h00, "timer ignored");
		alert_enable = 1'b0;
		drive(16'h0001);
		chk_pin(1'b0);
		alert_enable = 1'b1;
		repeat (4) @(negedge clk_sys);
		chk_pin(1'b1);
		chk({7'h00, alert_line_low}, 8'h01, "line low");
		drive(16'h0000);
		// results land, a read freezes them, high-byte reads release
		for (int c = 0; c < 4; c++) begin
			res[c] = 10'($urandom);
			conv(2'(c), res[c]);
		end
		lo = {res[3][1:0], res[2][1:0], res[1][1:0], res[0][1:0]};
		wr(ADDR_LOW_BITS, ~lo);
		rd(ADDR_LOW_BITS, lo);
		chk({7'h00, readback_frozen}, 8'h01, "frozen");
		conv(2'd2, ~res[2]);
		rd(ADDR_LOW_BITS, lo);
		for (int c = 0; c < 4; c++) rd(ADDR_HIGH_BASE + 8'(c), res[c][9:2]);
		@(negedge clk_sys);
		chk({7'h00, readback_frozen}, 8'h00, "released");
		conv(2'd2, ~res[2]);
		rd(ADDR_HIGH_BASE + 8'h02, ~res[2][9:2]);
		// second reset in mid-run clears the masks again
		masks(8'hA5, 8'h5A);
		nrst = 1'b0;
		@(negedge clk_sys);
		nrst = 1'b1;
		rd(ADDR_MASK_FIRST, MASK_RESET);
		rd(ADDR_MASK_SECOND, MASK_RESET);
		rd(ADDR_LOW_BITS, LOW_BITS_RESET);
		@(negedge clk_sys);
		report_and_stop();
	end
endmodule
